// ===== design/wki_top.sv
// module: wake input and interrupt output logic
// Function
// - rising and falling wake pin edges are both wake events.
// - in normal or stop mode an accepted edge raises an interrupt.
// - in sleep mode an accepted edge wakes the device; fail-safe mode requests restart instead.
// - modulation select in stop mode: low pin gives pfm, high gives pwm.
// - modulation select follows the pin without the wake filter.
// - static sense always watches the pin; cyclic only in active windows.
// - a pin level change is accepted only after a 16 us filter.
// - host sets wake enable; edges are wake sources only while it is 1, except the fail-safe restart request.
// - in normal and stop mode the pin level is readable.
// - from fail-safe mode any accepted edge requests restart.
// - a pin caused wake sets the pin source flag in status one.
// - two bit pull field: none, pull-down, pull-up, automatic.
// - automatic mode pulls up on high level, down on low level.
// - interrupt drives the pin low for 100 us then releases it high.
// - at least 100 us high between pulses; pending pulses wait.
// - an interrupt pulse never changes the operating mode.
// - status events signal interrupts only when enabled as wake source.
// - level status changes never produce an interrupt pulse.
// - entering stop with uncleared wake status gives an interrupt pulse.
// - in stop mode an automatic pfm to pwm switch gives a pulse.
// - visible status registers update at each interrupt falling edge.
// - latched flags stay set until the host clears them.
`timescale 1ns/1ns
`default_nettype none

module wki_top
    import wki_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rst_n,
    input  wire logic      wake_pin,
    input  wire wki_mode_t mode,
    input  wire wki_cfg_t  cfg,
    input  wire logic      cyclic_window,
    input  wire logic      buck_auto_pwm,
    input  wire logic      other_wake_event,
    input  wire logic      other_status_pending,
    input  wire logic      clear_wake_pin_flag,
    output wki_pull_t      pull,
    output logic           buck_pwm_sel,
    output logic           wake_level_status,
    output logic           wake_pin_source_flag,
    output logic           wake_pin_source_live,
    output logic           wake_up_req,
    output logic           restart_req,
    output logic           irq_n
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        IRQ_IDLE,
        IRQ_LOW,
        IRQ_GAP
    } wki_irq_st_t;

    typedef struct packed
    {
        wki_irq_st_t     irq_st;
        logic [CNT_W-1:0] irq_cnt;
        logic            irq_pend;
        logic            live_flag;
        logic            vis_flag;
        logic            lvl_stat;
        logic            pwm_sel;
        logic            pull_up;
        logic            pull_down;
        logic            wake_req;
        logic            rst_req;
        logic            irq_n;
        wki_mode_t       mode_q;
        logic            buck_q;
    } wki_state_t;

    localparam wki_state_t RESET_STATE = '{
        irq_st:    IRQ_IDLE,
        irq_cnt:   '0,
        irq_pend:  1'b0,
        live_flag: 1'b0,
        vis_flag:  1'b0,
        lvl_stat:  1'b0,
        pwm_sel:   1'b0,
        pull_up:   1'b0,
        pull_down: 1'b0,
        wake_req:  1'b0,
        rst_req:   1'b0,
        irq_n:     1'b1,
        mode_q:    WKI_MODE_NORMAL,
        buck_q:    1'b0
    };

    wki_state_t st_ff;
    wki_state_t nxt_st;

    logic raw_level;
    logic flt_level;
    logic flt_edge;

    // ------------------------------------------------------------
    // pin filter
    // ------------------------------------------------------------
    wki_filter u_filter
    (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .pin_in     (wake_pin),
        .raw_level  (raw_level),
        .level      (flt_level),
        .edge_pulse (flt_edge)
    );

    // ------------------------------------------------------------
    // event and interrupt logic
    // ------------------------------------------------------------
    logic active_mode;
    logic sensing;
    logic wake_evt;
    logic stop_entry;
    logic buck_rise;
    logic irq_evt;

    always_comb
    begin
        active_mode = (mode == WKI_MODE_NORMAL) || (mode == WKI_MODE_STOP);
        sensing     = !cfg.cyclic_sense || cyclic_window;
        // edge counts as wake source only while enabled
        wake_evt    = flt_edge && sensing && cfg.wake_pin_enable;
        stop_entry  = (mode == WKI_MODE_STOP) && (st_ff.mode_q != WKI_MODE_STOP);
        buck_rise   = (mode == WKI_MODE_STOP) && buck_auto_pwm && !st_ff.buck_q;
        // level status never feeds irq_evt
        irq_evt     = (active_mode && (wake_evt || other_wake_event))
                    || (stop_entry && (st_ff.live_flag || other_status_pending))
                    || buck_rise;

        nxt_st          = st_ff;
        nxt_st.mode_q   = mode;
        nxt_st.buck_q   = buck_auto_pwm;
        nxt_st.wake_req = wake_evt && (mode == WKI_MODE_SLEEP);
        nxt_st.rst_req  = flt_edge && sensing
                        && (mode == WKI_MODE_FAILSAFE);

        // set wins over clear
        if (wake_evt)
        begin
            nxt_st.live_flag = 1'b1;
        end
        else if (clear_wake_pin_flag)
        begin
            nxt_st.live_flag = 1'b0;
        end
        if (clear_wake_pin_flag && !wake_evt)
        begin
            nxt_st.vis_flag = 1'b0;
        end

        if (active_mode)
        begin
            nxt_st.lvl_stat = flt_level;
        end

        // unfiltered pin steers modulation in stop mode
        if (cfg.pin_selects_buck_modulation && (mode == WKI_MODE_STOP))
        begin
            nxt_st.pwm_sel = raw_level;
        end
        else
        begin
            nxt_st.pwm_sel = 1'b0;
        end

        unique case (cfg.wake_pull_select)
            PULL_NONE:
            begin
                nxt_st.pull_up   = 1'b0;
                nxt_st.pull_down = 1'b0;
            end
            PULL_DOWN:
            begin
                nxt_st.pull_up   = 1'b0;
                nxt_st.pull_down = 1'b1;
            end
            PULL_UP:
            begin
                nxt_st.pull_up   = 1'b1;
                nxt_st.pull_down = 1'b0;
            end
            PULL_AUTO:
            begin
                nxt_st.pull_up   = flt_level;
                nxt_st.pull_down = !flt_level;
            end
        endcase

        if (irq_evt)
        begin
            nxt_st.irq_pend = 1'b1;
        end

        // pulse sequencer; never touches mode
        unique case (st_ff.irq_st)
            IRQ_IDLE:
            begin
                if (st_ff.irq_pend || irq_evt)
                begin
                    nxt_st.irq_st   = IRQ_LOW;
                    nxt_st.irq_cnt  = '0;
                    nxt_st.irq_pend = 1'b0;
                    nxt_st.irq_n    = 1'b0;
                    nxt_st.vis_flag = st_ff.live_flag || wake_evt;
                end
            end
            IRQ_LOW:
            begin
                if (st_ff.irq_cnt == CNT_W'(IRQ_PULSE_CYC - 1))
                begin
                    nxt_st.irq_st  = IRQ_GAP;
                    nxt_st.irq_cnt = '0;
                    nxt_st.irq_n   = 1'b1;
                end
                else
                begin
                    nxt_st.irq_cnt = st_ff.irq_cnt + CNT_W'(1);
                end
            end
            IRQ_GAP:
            begin
                if (st_ff.irq_cnt == CNT_W'(IRQ_GAP_CYC - 1))
                begin
                    nxt_st.irq_st  = IRQ_IDLE;
                    nxt_st.irq_cnt = '0;
                end
                else
                begin
                    nxt_st.irq_cnt = st_ff.irq_cnt + CNT_W'(1);
                end
            end
            default:
            begin
                nxt_st.irq_st = IRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= RESET_STATE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pull.pull_up_en      = st_ff.pull_up;
    assign pull.pull_down_en    = st_ff.pull_down;
    assign buck_pwm_sel         = st_ff.pwm_sel;
    assign wake_level_status    = st_ff.lvl_stat;
    assign wake_pin_source_flag = st_ff.vis_flag;
    assign wake_pin_source_live = st_ff.live_flag;
    assign wake_up_req          = st_ff.wake_req;
    assign restart_req          = st_ff.rst_req;
    assign irq_n                = st_ff.irq_n;

endmodule

`default_nettype wire

// ===== design/wki_pkg.sv
// package: shared constants and carriers for the wake input and interrupt logic
package wki_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 100;
    localparam int unsigned WAKE_FILTER_US    = 16;
    localparam int unsigned IRQ_PULSE_US      = 100;
    localparam int unsigned IRQ_MIN_GAP_US    = 100;
    // least times round up
    localparam int unsigned WAKE_FILTER_CYC =
        (WAKE_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IRQ_PULSE_CYC =
        (IRQ_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IRQ_GAP_CYC =
        (IRQ_MIN_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 11;

    // ------------------------------------------------------------
    // pull select codes
    // ------------------------------------------------------------
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP   = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        WKI_MODE_NORMAL,
        WKI_MODE_STOP,
        WKI_MODE_SLEEP,
        WKI_MODE_FAILSAFE
    } wki_mode_t;

    typedef struct packed
    {
        logic       wake_pin_enable;
        logic       cyclic_sense;
        logic       pin_selects_buck_modulation;
        logic [1:0] wake_pull_select;
    } wki_cfg_t;

    typedef struct packed
    {
        logic pull_up_en;
        logic pull_down_en;
    } wki_pull_t;

    typedef struct packed
    {
        logic sync1;
        logic sync2;
        logic level;
        logic [CNT_W-1:0] cnt;
    } wki_flt_state_t;

endpackage

// ===== design/wki_filter.sv
// module: wake pin synchroniser and stability filter
`timescale 1ns/1ns
`default_nettype none

module wki_filter
    import wki_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      raw_level,
    output logic      level,
    output logic      edge_pulse
);

    wki_flt_state_t st_ff;
    wki_flt_state_t nxt_st;

    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.sync1 = pin_in;
        nxt_st.sync2 = st_ff.sync1;
        edge_pulse   = 1'b0;
        if (st_ff.sync2 == st_ff.level)
        begin
            nxt_st.cnt = '0;
        end
        else if (st_ff.cnt == CNT_W'(WAKE_FILTER_CYC - 1))
        begin
            nxt_st.level = st_ff.sync2;
            nxt_st.cnt   = '0;
            edge_pulse   = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign raw_level = st_ff.sync2;
    assign level     = st_ff.level;

endmodule

`default_nettype wire

// ===== tb/wki_top_assertions.sv
// checker: port assertions for the wake input and interrupt logic
`timescale 1ns/1ns
`default_nettype none

module wki_top_chk
    import wki_pkg::*;
(
    input wire logic      ref_clk,
    input wire logic      rst_n,
    input wire logic      wake_pin,
    input wire wki_mode_t mode,
    input wire wki_cfg_t  cfg,
    input wire wki_pull_t pull,
    input wire logic      buck_pwm_sel,
    input wire logic      wake_level_status,
    input wire logic      wake_pin_source_flag,
    input wire logic      wake_up_req,
    input wire logic      restart_req,
    input wire logic      irq_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // low, high and pin stability counters
    // ------------------------------------------------------------
    logic [10:0] lo_ff;
    logic [10:0] hi_ff;
    logic [10:0] st_ff;
    logic        pin_ff;
    logic        rel_ff;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lo_ff  <= 11'h0;
            hi_ff  <= 11'h3e8;
            st_ff  <= 11'h0;
            pin_ff <= 1'b0;
            rel_ff <= 1'b0;
        end
        else
        begin
            lo_ff  <= irq_n ? 11'h0 : lo_ff + 11'h1;
            hi_ff  <= !irq_n ? 11'h0 : ((hi_ff == 11'h3e8) ? hi_ff : hi_ff + 11'h1);
            st_ff  <= (wake_pin != pin_ff) ? 11'h0 : ((&st_ff) ? st_ff : st_ff + 11'h1);
            pin_ff <= wake_pin;
            rel_ff <= 1'b1;
        end
    end

    chk_irq_width: assert property ($rose(irq_n) |-> lo_ff == 11'h3e8)
        else $error("irq low time wrong");
    chk_irq_gap: assert property ($fell(irq_n) |-> hi_ff == 11'h3e8)
        else $error("irq high gap too short");
    chk_irq_modes: assert property ($fell(irq_n) |-> $past(mode) inside {WKI_MODE_NORMAL, WKI_MODE_STOP})
        else $error("irq outside normal or stop");
    chk_wake_sleep: assert property (wake_up_req |-> ($past(mode) == WKI_MODE_SLEEP && $past(cfg.wake_pin_enable)) ##1 !wake_up_req)
        else $error("wake request wrong");
    chk_restart_fs: assert property (restart_req |-> $past(mode) == WKI_MODE_FAILSAFE ##1 !restart_req)
        else $error("restart request wrong");
    chk_flag_update: assert property ($rose(wake_pin_source_flag) |-> $fell(irq_n))
        else $error("visible flag set off irq edge");
    chk_pwm_cause: assert property (buck_pwm_sel |-> $past(mode) == WKI_MODE_STOP && $past(cfg.pin_selects_buck_modulation))
        else $error("pwm selected outside stop feature");
    chk_level_filter: assert property ($changed(wake_level_status) |-> st_ff >= 11'h96)
        else $error("level accepted before filter time");
    chk_pull_fixed: assert property ((rel_ff && $stable(cfg.wake_pull_select) && cfg.wake_pull_select != PULL_AUTO) |-> pull == cfg.wake_pull_select)
        else $error("pull select wrong");
endmodule

bind wki_top wki_top_chk wki_top_chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .wake_pin(wake_pin),
    .mode(mode), .cfg(cfg), .pull(pull), .buck_pwm_sel(buck_pwm_sel),
    .wake_level_status(wake_level_status), .wake_pin_source_flag(wake_pin_source_flag),
    .wake_up_req(wake_up_req), .restart_req(restart_req), .irq_n(irq_n));

`default_nettype wire

// ===== tb/wki_host_model.sv
// host model: clears the wake pin source flag when asked
`timescale 1ns/1ns
`default_nettype none

module wki_host_model
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic irq_n,
    input  wire logic clr_req,
    output logic      clear_wake_pin_flag
);
    // one-cycle clear, only while the interrupt pin is released
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            clear_wake_pin_flag <= 1'b0;
        else
            clear_wake_pin_flag <= clr_req && irq_n && !clear_wake_pin_flag;
    end
endmodule

`default_nettype wire

// ===== tb/tb.sv
// testbench: drives the wake input and interrupt logic and checks its ports
`timescale 1ns/1ns
`default_nettype none

module tb
    import wki_pkg::*;
;
    logic        ref_clk  = 1'b0;
    logic        rst_n    = 1'b0;
    logic        wake_pin = 1'b0;
    wki_mode_t   mode     = WKI_MODE_NORMAL;
    wki_cfg_t    cfg      = '0;
    logic        cyc_win  = 1'b0;
    logic        auto_pwm = 1'b0;
    logic        oth_evt  = 1'b0;
    logic        oth_pend = 1'b0;
    logic        clr_req  = 1'b0;
    logic        clr;
    wki_pull_t   pull;
    logic        pwm_sel, lvl, flag, live, wup, rst_req, irq_n;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    int          g, w;
    logic [31:0] seed = 32'h1a5328a1;

    always #50 ref_clk = ~ref_clk;

    wki_top wki_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .wake_pin(wake_pin), .mode(mode),
        .cfg(cfg), .cyclic_window(cyc_win), .buck_auto_pwm(auto_pwm),
        .other_wake_event(oth_evt), .other_status_pending(oth_pend),
        .clear_wake_pin_flag(clr), .pull(pull), .buck_pwm_sel(pwm_sel),
        .wake_level_status(lvl), .wake_pin_source_flag(flag), .wake_pin_source_live(live),
        .wake_up_req(wup), .restart_req(rst_req), .irq_n(irq_n));
    wki_host_model wki_host_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .irq_n(irq_n),
        .clr_req(clr_req), .clear_wake_pin_flag(clr));

    // ------------------------------------------------------------
    // model, drivers and compare
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [1:0] exp_pull(input logic [1:0] c, input logic l);
        return (c == PULL_AUTO) ? (l ? PULL_UP : PULL_DOWN) : c;
    endfunction

    task automatic report_and_stop;
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task automatic quiet(input int n);
        int lows;
        lows = 0;
        repeat (n)
        begin
            tick(1);
            lows += (irq_n !== 1'b1);
        end
        cmp("irq_quiet", 0, lows);
    endtask

    // high time before the next pulse, then its low time
    task automatic get_pulse(output int hg, output int lw);
        hg = 0;
        lw = 0;
        while (irq_n !== 1'b0 || lw > 1100)
        begin
            tick(1);
            hg++;
            if (hg > 1300)
            begin
                n_mismatch++;
                report_and_stop();
            end
        end
        while (irq_n === 1'b0 && lw <= 1100)
        begin
            tick(1);
            lw++;
        end
    endtask

    task automatic wait_one(ref logic s, input string nm);
        int k;
        k = 0;
        while (s !== 1'b1 && k < 300)
        begin
            tick(1);
            k++;
        end
        if (k == 300)
        begin
            n_mismatch++;
            report_and_stop();
        end
        tick(1);
        cmp(nm, 0, s);
    endtask

    task automatic host_clear;
        clr_req = 1'b1;
        tick(2);
        clr_req = 1'b0;
        tick(3);
        cmp("live", 0, live);
    endtask

    initial
    begin
        tick(12);
        rst_n = 1'b1;
        cmp("irq_n", 1, irq_n);
        for (int c = 0; c < 4; c++)
        begin
            cfg.wake_pull_select = c[1:0];
            tick(2);
            cmp("pull", exp_pull(c[1:0], 1'b0), pull);
        end
        cfg.wake_pin_enable = 1'b1;
        repeat (4)
        begin
            seed = xs(seed);
            wake_pin = 1'b1;
            tick(20 + seed[6:0]);
            wake_pin = 1'b0;
            quiet(170);
            cmp("level", 0, lvl);
        end
        wake_pin = 1'b1;
        get_pulse(g, w);
        cmp("width", 1000, w);
        cmp("level", 1, lvl);
        cmp("live", 1, live);
        cmp("pull", exp_pull(PULL_AUTO, 1'b1), pull);
        wake_pin = 1'b0;
        get_pulse(g, w);
        cmp("gap", 1, g >= 1000);
        cmp("width", 1000, w);
        cmp("flag", 1, flag);
        quiet(50);
        cmp("flag", 1, flag);
        host_clear();
        cfg.wake_pin_enable = 1'b0;
        wake_pin = 1'b1;
        quiet(400);
        cmp("level", 1, lvl);
        oth_evt = 1'b1;
        tick(1);
        oth_evt = 1'b0;
        get_pulse(g, w);
        cmp("width", 1000, w);
        cfg.wake_pin_enable = 1'b1;
        cfg.cyclic_sense = 1'b1;
        wake_pin = 1'b0;
        quiet(400);
        cmp("level", 0, lvl);
        cyc_win = 1'b1;
        wake_pin = 1'b1;
        get_pulse(g, w);
        cmp("width", 1000, w);
        cyc_win = 1'b0;
        cfg.cyclic_sense = 1'b0;
        mode = WKI_MODE_SLEEP;
        wake_pin = 1'b0;
        wait_one(wup, "wake_up_req");
        cmp("live", 1, live);
        cmp("irq_n", 1, irq_n);
        mode = WKI_MODE_FAILSAFE;
        cfg.wake_pin_enable = 1'b0;
        wake_pin = 1'b1;
        wait_one(rst_req, "restart_req");
        mode = WKI_MODE_STOP;
        get_pulse(g, w);
        cmp("width", 1000, w);
        host_clear();
        cfg.pin_selects_buck_modulation = 1'b1;
        wake_pin = 1'b1;
        tick(8);
        cmp("pwm_sel", 1, pwm_sel);
        wake_pin = 1'b0;
        tick(8);
        cmp("pwm_sel", 0, pwm_sel);
        auto_pwm = 1'b1;
        get_pulse(g, w);
        cmp("width", 1000, w);
        report_and_stop();
    end
endmodule

`default_nettype wire
